// >>> core/pdsr_pkg.sv
// Contract
// - Writing one to the cable-test run bit starts the diagnostic, and the device clears that bit itself when the test ends.
// - A zero read from the run bit means the test is over and the outcome fields may be read.
// - The two-bit outcome reads 00 normal, 01 open, 10 short, 11 diagnostic failed.
// - A read-only flag reads one when the diagnostic finds a short nearer than ten metres.
// - A nine-bit read-only count holds the distance to the fault, about 0.4 m per step.
// - The diagnostic register at address 0x1D exists only on the second PHY, not on the first.
// - Bit 5 of the special register reads one when receive polarity is reversed, valid only in 10BASE-T.
// - The power-saving bit resets to one (saving off), and writing zero turns power saving on.
// - Bit 1 of a port's special register puts that port into remote loopback; it resets to zero.
// - In remote loopback, data received on the port is looped at its PHY's medium layers and sent on its transmit pair.
package pdsr_pkg;

  // ****************************************
  // Addresses
  // ****************************************
  localparam logic [4:0] PHY_ADDR_P1 = 5'h01;
  localparam logic [4:0] PHY_ADDR_P2 = 5'h02;
  localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
  localparam logic [4:0] REG_SPECIAL = 5'h1F;
  localparam logic [7:0] SW_P1_CTL = 8'h1A;
  localparam logic [7:0] SW_P1_STAT0 = 8'h1E;
  localparam logic [7:0] SW_P1_STAT1 = 8'h1F;
  localparam logic [7:0] SW_P2_CTL = 8'h2A;
  localparam logic [7:0] SW_P2_DIST = 8'h2B;
  localparam logic [7:0] SW_P2_STAT0 = 8'h2E;
  localparam logic [7:0] SW_P2_STAT1 = 8'h2F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DIAG_RUN_BIT = 15;
  localparam int DIAG_RES_LSB = 13;
  localparam int DIAG_SHORT_BIT = 12;
  localparam int DIAG_CNT_LSB = 0;
  localparam int SPC_POLREV_BIT = 5;
  localparam int SPC_MDI_BIT = 4;
  localparam int SPC_FORCE_BIT = 3;
  localparam int SPC_PWRSAVE_BIT = 2;
  localparam int SPC_LOOP_BIT = 1;
  localparam int SPC_RSVD0_BIT = 0;
  localparam int SW_MDI_BIT = 7;
  localparam int SW_POL_BIT = 5;
  localparam int SW_SHORT_BIT = 7;
  localparam int SW_RES_LSB = 5;
  localparam int SW_RUN_BIT = 4;
  localparam int SW_FORCE_BIT = 3;
  localparam int SW_PWRSAVE_BIT = 2;
  localparam int SW_LOOP_BIT = 1;
  localparam int SW_CNT8_BIT = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_FORCE = 1'h0;
  localparam logic RST_PWRSAVE_DIS = 1'h1;
  localparam logic RST_LOOP = 1'h0;
  localparam logic RST_RSVD0 = 1'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CT_IDLE = 2'h0,
    CT_START = 2'h1,
    CT_WAIT = 2'h3
  } pdsr_ct_state_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [4:0] phyAd;
    logic [4:0] regAd;
    logic [15:0] wdata;
  } pdsr_mgmt_req_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pdsr_sw_req_t;

  typedef struct packed {
    logic polRev;
    logic mdiStat;
  } pdsr_phy_stat_t;

  typedef struct packed {
    logic linkPassOverride;
    logic powerSaveDis;
    logic remoteLoop;
    logic rsvd0;
  } pdsr_port_ctl_t;

  typedef struct packed {
    logic [1:0] result;
    logic nearShortFlag;
    logic [8:0] faultCount;
  } pdsr_diag_res_t;

endpackage : pdsr_pkg

// >>> core/pdsr_cable_test.sv
`timescale 1ns/1ns
module pdsr_cable_test
  import pdsr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Async reset
  input wire logic startReq, // Start request pulse
  input wire logic anaDone, // Analog test done pulse
  input wire pdsr_diag_res_t anaRes, // Analog test outcome
  output logic busy, // Test running
  output logic anaStart, // Analog test start pulse
  output pdsr_diag_res_t diagRes // Latched outcome
);

  typedef struct packed {
    pdsr_ct_state_t fsm;
    logic busy;
    logic anaStart;
    pdsr_diag_res_t res;
  } pdsr_ct_st_t;

  pdsr_ct_st_t st_ff;
  pdsr_ct_st_t nxt_st;

  // ****************************************
  // Test sequencer
  // ****************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.anaStart = 1'b0;
    case (st_ff.fsm)
      CT_IDLE:
      begin
        if (startReq)
        begin
          nxt_st.fsm = CT_START;
          nxt_st.busy = 1'b1;
          nxt_st.anaStart = 1'b1;
        end
      end
      CT_START:
      begin
        nxt_st.fsm = CT_WAIT;
      end
      CT_WAIT:
      begin
        if (anaDone)
        begin
          nxt_st.res = anaRes;
          nxt_st.busy = 1'b0;
          nxt_st.fsm = CT_IDLE;
        end
      end
      default:
      begin
        nxt_st.fsm = CT_IDLE;
        nxt_st.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign busy = st_ff.busy;
  assign anaStart = st_ff.anaStart;
  assign diagRes = st_ff.res;

endmodule : pdsr_cable_test

// >>> core/pdsr_regs.sv
`timescale 1ns/1ns
module pdsr_regs
  import pdsr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Async reset
  input wire pdsr_mgmt_req_t mgmtReq, // MII management access
  output logic mgmtRdValid, // Read data valid pulse
  output logic [15:0] mgmtRdData, // Read data
  input wire pdsr_sw_req_t swReq, // 8-bit switch register access
  output logic swRdValid, // Switch read valid pulse
  output logic [7:0] swRdData, // Switch read data
  input wire pdsr_phy_stat_t [1:0] phyStat, // PHY status per port
  input wire logic anaDone, // Cable test done pulse
  input wire pdsr_diag_res_t anaRes, // Cable test outcome
  output logic anaStart, // Cable test start pulse
  output pdsr_port_ctl_t [1:0] portCtl // Per-port PHY controls
);

  typedef struct packed {
    pdsr_port_ctl_t [1:0] port;
    logic rdValid;
    logic [15:0] rdData;
    logic swValid;
    logic [7:0] swData;
  } pdsr_regs_st_t;

  pdsr_regs_st_t st_ff;
  pdsr_regs_st_t nxt_st;
  logic startTest;
  logic testBusy;
  pdsr_diag_res_t diagRes;
  logic mgmtWr;
  logic mgmtRd;
  logic swWr;
  logic swRd;

  // ****************************************
  // Request decode
  // ****************************************
  assign mgmtWr = mgmtReq.req & mgmtReq.write;
  assign mgmtRd = mgmtReq.req & ~mgmtReq.write;
  assign swWr = swReq.req & swReq.write;
  assign swRd = swReq.req & ~swReq.write;

  // ****************************************
  // Cable diagnostic engine (second PHY)
  // ****************************************
  pdsr_cable_test u_cable_test (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .startReq(startTest),
    .anaDone(anaDone),
    .anaRes(anaRes),
    .busy(testBusy),
    .anaStart(anaStart),
    .diagRes(diagRes)
  );

  // ****************************************
  // Read views
  // ****************************************
  function automatic logic [15:0] spcView(input pdsr_port_ctl_t c, input pdsr_phy_stat_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[SPC_POLREV_BIT] = s.polRev;
    v[SPC_MDI_BIT] = s.mdiStat;
    v[SPC_FORCE_BIT] = c.linkPassOverride;
    v[SPC_PWRSAVE_BIT] = c.powerSaveDis;
    v[SPC_LOOP_BIT] = c.remoteLoop;
    v[SPC_RSVD0_BIT] = c.rsvd0;
    return v;
  endfunction : spcView

  function automatic logic [7:0] swCtlView(input pdsr_port_ctl_t c);
    logic [7:0] v;
    v = 8'h00;
    v[SW_FORCE_BIT] = c.linkPassOverride;
    v[SW_PWRSAVE_BIT] = c.powerSaveDis;
    v[SW_LOOP_BIT] = c.remoteLoop;
    return v;
  endfunction : swCtlView

  // ****************************************
  // Register file
  // ****************************************
  always_comb
  begin
    logic isP1;
    logic isP2;
    logic [7:0] sv;
    isP1 = (mgmtReq.phyAd == PHY_ADDR_P1);
    isP2 = (mgmtReq.phyAd == PHY_ADDR_P2);
    sv = 8'h00;
    nxt_st = st_ff;
    nxt_st.rdValid = 1'b0;
    nxt_st.swValid = 1'b0;
    startTest = 1'b0;

    // Switch-side writes, overridden below by a same-cycle MII write to that port's special register
    if (swWr)
    begin
      case (swReq.addr)
        SW_P1_CTL:
        begin
          nxt_st.port[0].linkPassOverride = swReq.wdata[SW_FORCE_BIT];
          nxt_st.port[0].powerSaveDis = swReq.wdata[SW_PWRSAVE_BIT];
          nxt_st.port[0].remoteLoop = swReq.wdata[SW_LOOP_BIT];
        end
        SW_P2_CTL:
        begin
          nxt_st.port[1].linkPassOverride = swReq.wdata[SW_FORCE_BIT];
          nxt_st.port[1].powerSaveDis = swReq.wdata[SW_PWRSAVE_BIT];
          nxt_st.port[1].remoteLoop = swReq.wdata[SW_LOOP_BIT];
          startTest = swReq.wdata[SW_RUN_BIT];
        end
        default:
        begin
          sv = 8'h00;
        end
      endcase
    end

    // MII management writes
    if (mgmtWr && mgmtReq.regAd == REG_SPECIAL && (isP1 || isP2))
    begin
      nxt_st.port[isP2].linkPassOverride = mgmtReq.wdata[SPC_FORCE_BIT];
      nxt_st.port[isP2].powerSaveDis = mgmtReq.wdata[SPC_PWRSAVE_BIT];
      nxt_st.port[isP2].remoteLoop = mgmtReq.wdata[SPC_LOOP_BIT];
      nxt_st.port[isP2].rsvd0 = mgmtReq.wdata[SPC_RSVD0_BIT];
    end
    if (mgmtWr && isP2 && mgmtReq.regAd == REG_CABLE_DIAG && mgmtReq.wdata[DIAG_RUN_BIT])
    begin
      startTest = 1'b1;
    end

    // MII management reads
    if (mgmtRd)
    begin
      nxt_st.rdValid = 1'b1;
      nxt_st.rdData = 16'h0000;
      if (mgmtReq.regAd == REG_SPECIAL && (isP1 || isP2))
      begin
        nxt_st.rdData = spcView(st_ff.port[isP2], phyStat[isP2]);
      end
      else if (mgmtReq.regAd == REG_CABLE_DIAG && isP2)
      begin
        nxt_st.rdData[DIAG_RUN_BIT] = testBusy;
        nxt_st.rdData[DIAG_RES_LSB +: 2] = diagRes.result;
        nxt_st.rdData[DIAG_SHORT_BIT] = diagRes.nearShortFlag;
        nxt_st.rdData[DIAG_CNT_LSB +: 9] = diagRes.faultCount;
      end
    end

    // Switch-side reads of the mirrored bits
    if (swRd)
    begin
      case (swReq.addr)
        SW_P1_CTL:
        begin
          sv = swCtlView(st_ff.port[0]);
        end
        SW_P2_CTL:
        begin
          sv = swCtlView(st_ff.port[1]);
          sv[SW_SHORT_BIT] = diagRes.nearShortFlag;
          sv[SW_RES_LSB +: 2] = diagRes.result;
          sv[SW_RUN_BIT] = testBusy;
          sv[SW_CNT8_BIT] = diagRes.faultCount[8];
        end
        SW_P2_DIST:
        begin
          sv = diagRes.faultCount[7:0];
        end
        SW_P1_STAT0:
        begin
          sv[SW_MDI_BIT] = phyStat[0].mdiStat;
        end
        SW_P2_STAT0:
        begin
          sv[SW_MDI_BIT] = phyStat[1].mdiStat;
        end
        SW_P1_STAT1:
        begin
          sv[SW_POL_BIT] = phyStat[0].polRev;
        end
        SW_P2_STAT1:
        begin
          sv[SW_POL_BIT] = phyStat[1].polRev;
        end
        default:
        begin
          sv = 8'h00;
        end
      endcase
      nxt_st.swValid = 1'b1;
      nxt_st.swData = sv;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.port[0] <= '{RST_FORCE, RST_PWRSAVE_DIS, RST_LOOP, RST_RSVD0};
      st_ff.port[1] <= '{RST_FORCE, RST_PWRSAVE_DIS, RST_LOOP, RST_RSVD0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign mgmtRdValid = st_ff.rdValid;
  assign mgmtRdData = st_ff.rdData;
  assign swRdValid = st_ff.swValid;
  assign swRdData = st_ff.swData;
  assign portCtl = st_ff.port;

endmodule : pdsr_regs

// >>> verif/pdsr_regs_chk.sv
`timescale 1ns/1ns
module pdsr_regs_chk
  import pdsr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset
  input wire pdsr_mgmt_req_t mgmtReq, // MII req
  input wire logic mgmtRdValid, // Valid
  input wire logic [15:0] mgmtRdData, // Data
  input wire pdsr_sw_req_t swReq, // Switch req
  input wire pdsr_phy_stat_t [1:0] phyStat, // Status
  input wire logic anaStart, // Start
  input wire logic anaDone, // Done
  input wire pdsr_port_ctl_t [1:0] portCtl // Controls
);
  logic rd;
  logic wr;
  logic p2;
  assign rd = mgmtReq.req & ~mgmtReq.write;
  assign wr = mgmtReq.req & mgmtReq.write;
  assign p2 = mgmtReq.phyAd == PHY_ADDR_P2;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_src;
    anaStart |-> $past(wr && p2 && mgmtReq.regAd == REG_CABLE_DIAG && mgmtReq.wdata[15]
      || swReq.req && swReq.write && swReq.addr == SW_P2_CTL && swReq.wdata[4]);
  endproperty
  a_src: assert property (p_src) else $error("stray start");
  property p_pulse;
    anaStart |=> !anaStart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start too long");
  property p_rsvS;
    rd && mgmtReq.regAd == REG_SPECIAL |=> mgmtRdValid && mgmtRdData[15:6] == 10'h000;
  endproperty
  a_rsvS: assert property (p_rsvS) else $error("special reserved");
  property p_rsvD;
    rd && p2 && mgmtReq.regAd == REG_CABLE_DIAG |=> mgmtRdData[11:9] == 3'h0;
  endproperty
  a_rsvD: assert property (p_rsvD) else $error("diag reserved");
  property p_p1d;
    rd && mgmtReq.phyAd == PHY_ADDR_P1 && mgmtReq.regAd == REG_CABLE_DIAG |=> mgmtRdData == 16'h0000;
  endproperty
  a_p1d: assert property (p_p1d) else $error("first diag");
  property p_pol;
    rd && p2 && mgmtReq.regAd == REG_SPECIAL |=> mgmtRdData[5] == $past(phyStat[1].polRev);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
  property p_loop;
    wr && mgmtReq.phyAd == PHY_ADDR_P1 && mgmtReq.regAd == REG_SPECIAL
      |=> portCtl[0].remoteLoop == $past(mgmtReq.wdata[1]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback");
  property p_pwr;
    wr && p2 && mgmtReq.regAd == REG_SPECIAL |=> portCtl[1].powerSaveDis == $past(mgmtReq.wdata[2]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power save");
  c_start: cover property (anaStart);
  c_done: cover property (anaDone);
  c_sw: cover property (swReq.req && !swReq.write);
endmodule : pdsr_regs_chk

bind pdsr_regs pdsr_regs_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .mgmtReq(mgmtReq),
  .mgmtRdValid(mgmtRdValid), .mgmtRdData(mgmtRdData), .swReq(swReq), .phyStat(phyStat),
  .anaStart(anaStart), .anaDone(anaDone), .portCtl(portCtl));

// >>> verif/pdsr_ana_model.sv
`timescale 1ns/1ns
module pdsr_ana_model
  import pdsr_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic anaStart, // Start
  input wire logic [7:0] delay, // Test length
  input wire pdsr_diag_res_t res, // Outcome
  output logic anaDone, // Done
  output pdsr_diag_res_t anaRes // Outcome out
);
  logic [7:0] cnt;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= 8'h00;
      anaDone <= 1'b0;
      anaRes <= '0;
    end
    else
    begin
      anaDone <= cnt == 8'h01;
      anaRes <= (cnt == 8'h01) ? res : ~anaRes;
      cnt <= anaStart ? delay : (cnt != 8'h00) ? cnt - 8'h01 : cnt;
    end
  end
endmodule : pdsr_ana_model

// >>> verif/tb.sv
`timescale 1ns/1ns
module tb;
  import pdsr_pkg::*;
  localparam logic [8:0] CNTS [4] = '{9'h000, 9'h1FF, 9'h100, 9'h0AA};
  logic core_clk;
  logic reset_n;
  pdsr_mgmt_req_t mgmtReq;
  pdsr_sw_req_t swReq;
  pdsr_phy_stat_t [1:0] phyStat;
  logic mgmtRdValid;
  logic [15:0] mgmtRdData;
  logic swRdValid;
  logic [7:0] swRdData;
  logic anaDone;
  logic anaStart;
  pdsr_diag_res_t anaRes;
  pdsr_diag_res_t res;
  logic [7:0] delay;
  pdsr_port_ctl_t [1:0] portCtl;
  logic [15:0] rd;
  logic [7:0] rd8;
  logic startSeen;
  int miscompares;
  int compares;
  pdsr_regs dut (.core_clk(core_clk), .reset_n(reset_n), .mgmtReq(mgmtReq), .mgmtRdValid(mgmtRdValid),
    .mgmtRdData(mgmtRdData), .swReq(swReq), .swRdValid(swRdValid), .swRdData(swRdData), .phyStat(phyStat),
    .anaDone(anaDone), .anaRes(anaRes), .anaStart(anaStart), .portCtl(portCtl));
  pdsr_ana_model u_ana (.core_clk(core_clk), .reset_n(reset_n), .anaStart(anaStart), .delay(delay),
    .res(res), .anaDone(anaDone), .anaRes(anaRes));
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk16({8'h00, got}, {8'h00, exp});
  endtask : chk8
  task automatic mg(input logic w, input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
    mgmtReq = '{1'b1, w, p, r, d};
    @(posedge core_clk);
    #1 mgmtReq.req = 1'b0;
    rd = mgmtRdData;
    startSeen = anaStart;
    if (!w) chk16({15'h0, mgmtRdValid}, 16'h0001);
    @(posedge core_clk);
    #1 if (!w) chk16({15'h0, mgmtRdValid}, 16'h0000);
  endtask : mg
  task automatic sw(input logic w, input logic [7:0] a, input logic [7:0] d);
    swReq = '{1'b1, w, a, d};
    @(posedge core_clk);
    #1 swReq.req = 1'b0;
    rd8 = swRdData;
    startSeen = anaStart;
    if (!w) chk8({7'h0, swRdValid}, 8'h01);
    @(posedge core_clk);
    #1 if (!w) chk8({7'h0, swRdValid}, 8'h00);
  endtask : sw
  task automatic t_reset;
    mg(0, PHY_ADDR_P1, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h0014);
    mg(0, PHY_ADDR_P2, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h0024);
    chk16({8'h00, portCtl}, 16'h0044);
  endtask : t_reset
  task automatic t_ctl;
    mg(1, PHY_ADDR_P1, REG_SPECIAL, 16'hFFCA);
    mg(0, PHY_ADDR_P1, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h001A);
    chk16({12'h0, portCtl[0]}, 16'h000A);
    sw(0, SW_P1_CTL, 8'h00);
    chk8(rd8 & 8'h0E, 8'h0A);
    sw(1, SW_P2_CTL, 8'h02);
    mg(0, PHY_ADDR_P2, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h0022);
    mg(1, PHY_ADDR_P2, REG_SPECIAL, 16'h0006);
    chk16({12'h0, portCtl[1]}, 16'h0006);
  endtask : t_ctl
  task automatic t_stat;
    phyStat = 4'h6;
    sw(0, SW_P1_STAT0, 8'h00);
    chk8(rd8, 8'h00);
    sw(0, SW_P2_STAT0, 8'h00);
    chk8(rd8, 8'h80);
    sw(0, SW_P1_STAT1, 8'h00);
    chk8(rd8, 8'h20);
    sw(0, SW_P2_STAT1, 8'h00);
    chk8(rd8, 8'h00);
    mg(0, PHY_ADDR_P1, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h002A);
    mg(0, PHY_ADDR_P2, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h0016);
  endtask : t_stat
  task automatic t_diag;
    for (int i = 0; i < 4; i++)
    begin
      res = '{i[1:0], i[0], CNTS[i]};
      delay = 8'(3 + i);
      mg(1, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h8000);
      chk16({15'h0, startSeen}, 16'h0001);
      mg(0, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h0000);
      chk16(rd & 16'h8000, 16'h8000);
      for (int k = 0; k < 20 && rd[15]; k++) mg(0, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h0000);
      chk16(rd, {1'b0, i[1:0], i[0], 3'h0, CNTS[i]});
      sw(0, SW_P2_CTL, 8'h00);
      chk8(rd8 & 8'hF1, {i[0], i[1:0], 4'h0, CNTS[i][8]});
      sw(0, SW_P2_DIST, 8'h00);
      chk8(rd8, CNTS[i][7:0]);
    end
    sw(1, SW_P2_CTL, 8'h16);
    chk8({7'h0, startSeen}, 8'h01);
    mg(1, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h8000);
    chk8({7'h0, startSeen}, 8'h00);
    rd = 16'h8000;
    for (int k = 0; k < 20 && rd[15]; k++) mg(0, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h0000);
    chk16(rd, 16'h70AA);
  endtask : t_diag
  task automatic t_refuse;
    mg(1, PHY_ADDR_P1, REG_CABLE_DIAG, 16'h8000);
    chk16({15'h0, startSeen}, 16'h0000);
    mg(0, PHY_ADDR_P1, REG_CABLE_DIAG, 16'h0000);
    chk16(rd, 16'h0000);
    mg(0, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h0000);
    chk16(rd & 16'h8000, 16'h0000);
  endtask : t_refuse
  task automatic t_rerst;
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    mg(0, PHY_ADDR_P2, REG_SPECIAL, 16'h0000);
    chk16(rd, 16'h0014);
    mg(0, PHY_ADDR_P2, REG_CABLE_DIAG, 16'h0000);
    chk16(rd, 16'h0000);
  endtask : t_rerst
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  initial
  begin
    reset_n = 1'b0;
    mgmtReq = '0;
    swReq = '0;
    phyStat = 4'h9;
    res = '0;
    delay = 8'h03;
    repeat (20) @(posedge core_clk);
    #1 reset_n = 1'b1;
    t_reset();
    t_ctl();
    t_stat();
    t_diag();
    t_refuse();
    t_rerst();
    final_report();
  end
  initial
  begin
    #40000;
    miscompares++;
    final_report();
  end
endmodule : tb
